// ==== wdt_watchdog_timeout_reset.v ====
// How it works
// - When enabled, reaching the selected overflow count before a service write forces a system reset.
// - Any reset, including the watchdog's own, sets the enable bit again.
// - With the enable bit clear the counter stays at zero and never fires.
// - Writing any value to the reset cause address clears the counter and leaves that register unchanged.
// - The clock select bit picks the internal slow tick at 0 and the bus clock at 1.
// - On the internal tick the timeout select gives 2^10 ticks at 0 and 2^13 ticks at 1.
// - On the bus clock the timeout select gives 2^13 cycles at 0 and 2^18 cycles at 1.
// - After reset the internal tick and the long timeout are selected.
// - Internal timeouts are tick counts, so their real time scales with the internal tick period (1 ms nominal).
// - Each option register takes only its first write after reset, so software writes both early.
// - That first write to either option register also clears the counter.
// - In background debug mode the counter holds.
// - On the bus clock the counter freezes in stop mode and resumes from its held value.
// - On the internal tick the counter is cleared on stop entry and restarts from zero after stop.
// - A watchdog reset sets the watchdog bit of the reset cause register.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"

module wdt_watchdog_timeout_reset #(
    parameter RESET_PULSE_CYCLES = `WDT_RESET_PULSE_CYCLES
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [`WDT_ADDR_W-1:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire pready_out,
    output reg [31:0] prdata_out,
    output reg pslverr_out,
    // Internal slow clock source
    input wire slow_clk_in,
    // Processor state, same clock domain
    input wire stop_mode_in,
    input wire debug_mode_in,
    // System reset request and status
    output reg system_reset_out,
    output wire watchdog_enable_out
);

// ****************************************************************
// Reset synchroniser
// ****************************************************************
reg rst_meta;
reg rst_n_sync;

always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        rst_meta <= 1'b0;
        rst_n_sync <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_n_sync <= rst_meta;
    end
end

// ****************************************************************
// Overflow count selection
// ****************************************************************
// The returned value is the count at which the watchdog fires. On the
// internal tick it is a number of ticks, never a number of bus cycles.
function [`WDT_CNT_W:0] overflow_limit;
    input clock_sel;
    input timeout_sel;
    begin
        if (clock_sel) begin
            if (timeout_sel) begin
                overflow_limit = `WDT_LIMIT_ONE << `WDT_EXP_BUS_LONG;
            end else begin
                overflow_limit = `WDT_LIMIT_ONE << `WDT_EXP_BUS_SHORT;
            end
        end else begin
            if (timeout_sel) begin
                overflow_limit = `WDT_LIMIT_ONE << `WDT_EXP_INT_LONG;
            end else begin
                overflow_limit = `WDT_LIMIT_ONE << `WDT_EXP_INT_SHORT;
            end
        end
    end
endfunction

// ****************************************************************
// Slow tick
// ****************************************************************
wire slow_tick;

wdt_tick_sync i_wdt_tick_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_sync),
    .slow_clk_in(slow_clk_in),
    .tick_out(slow_tick)
);

// ****************************************************************
// State
// ****************************************************************
reg watchdog_enable;
reg watchdog_timeout_select;
reg watchdog_clock_select;
reg lock_first;
reg lock_second;
reg cause_power;
reg cause_watchdog;
reg [`WDT_CNT_W-1:0] watchdog_count;
reg [`WDT_PULSE_W-1:0] pulse_count;

reg [`WDT_CNT_W-1:0] next_watchdog_count;
reg [31:0] next_read_word;
reg next_error;
reg advance;
reg clear_count;
reg fire;

wire setup_phase;
wire write_access;
wire hit_cause;
wire hit_first;
wire hit_second;
wire hit_status;
wire first_write_first;
wire first_write_second;
wire service_write;
wire pulse_active;
wire [`WDT_CNT_W:0] count_plus;
wire [`WDT_CNT_W:0] limit;

assign pulse_active = system_reset_out;
assign watchdog_enable_out = watchdog_enable;

// ****************************************************************
// APB decode
// ****************************************************************
// The slave never inserts wait states; read data and the error flag are
// captured in the setup cycle so they come from flip-flops in the access.
assign pready_out = 1'b1;
assign setup_phase = psel_in & ~penable_in;
assign write_access = psel_in & penable_in & pwrite_in & ~pulse_active;

assign hit_cause = (paddr_in == `WDT_OFS_RESET_CAUSE);
assign hit_first = (paddr_in == `WDT_OFS_OPTIONS_FIRST);
assign hit_second = (paddr_in == `WDT_OFS_OPTIONS_SECOND);
assign hit_status = (paddr_in == `WDT_OFS_STATUS);

assign first_write_first = write_access & hit_first & ~lock_first;
assign first_write_second = write_access & hit_second & ~lock_second;
assign service_write = write_access & hit_cause;

always @* begin
    next_read_word = `WDT_RST_WORD;
    next_error = 1'b0;
    if (hit_cause) begin
        next_read_word[`WDT_BIT_CAUSE_POWER] = cause_power;
        next_read_word[`WDT_BIT_CAUSE_WATCHDOG] = cause_watchdog;
    end else if (hit_first) begin
        next_read_word[`WDT_BIT_ENABLE] = watchdog_enable;
        next_read_word[`WDT_BIT_TIMEOUT_SEL] = watchdog_timeout_select;
    end else if (hit_second) begin
        next_read_word[`WDT_BIT_CLOCK_SEL] = watchdog_clock_select;
    end else if (hit_status) begin
        next_read_word[`WDT_CNT_W-1:0] = watchdog_count;
        next_read_word[`WDT_BIT_LOCK_FIRST] = lock_first;
        next_read_word[`WDT_BIT_LOCK_SECOND] = lock_second;
        next_read_word[`WDT_BIT_RESET_ACTIVE] = pulse_active;
    end else begin
        next_error = 1'b1;
    end
end

always @(posedge clk_in or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
        prdata_out <= `WDT_RST_WORD;
        pslverr_out <= 1'b0;
    end else if (setup_phase) begin
        prdata_out <= next_read_word;
        pslverr_out <= next_error;
    end
end

// ****************************************************************
// Option registers, write once
// ****************************************************************
// The watchdog's own reset returns the options to their defaults and
// unlocks them, just as a pin or power-on reset does.
always @(posedge clk_in or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
        watchdog_enable <= `WDT_RST_ENABLE;
        watchdog_timeout_select <= `WDT_RST_TIMEOUT_SEL;
        watchdog_clock_select <= `WDT_RST_CLOCK_SEL;
        lock_first <= 1'b0;
        lock_second <= 1'b0;
    end else if (pulse_active) begin
        watchdog_enable <= `WDT_RST_ENABLE;
        watchdog_timeout_select <= `WDT_RST_TIMEOUT_SEL;
        watchdog_clock_select <= `WDT_RST_CLOCK_SEL;
        lock_first <= 1'b0;
        lock_second <= 1'b0;
    end else begin
        if (first_write_first) begin
            watchdog_enable <= pwdata_in[`WDT_BIT_ENABLE];
            watchdog_timeout_select <= pwdata_in[`WDT_BIT_TIMEOUT_SEL];
            lock_first <= 1'b1;
        end
        if (first_write_second) begin
            watchdog_clock_select <= pwdata_in[`WDT_BIT_CLOCK_SEL];
            lock_second <= 1'b1;
        end
    end
end

// ****************************************************************
// Watchdog counter
// ****************************************************************
assign limit = overflow_limit(watchdog_clock_select, watchdog_timeout_select);
assign count_plus = {1'b0, watchdog_count} + `WDT_LIMIT_ONE;

always @* begin
    advance = 1'b0;
    clear_count = 1'b0;
    fire = 1'b0;
    next_watchdog_count = watchdog_count;
    // Step source: every bus cycle, or one step per slow tick.
    if (watchdog_clock_select) begin
        advance = 1'b1;
    end else begin
        advance = slow_tick;
    end
    if (debug_mode_in) begin
        advance = 1'b0;
    end
    if (stop_mode_in && watchdog_clock_select) begin
        advance = 1'b0;
    end
    if (stop_mode_in && !watchdog_clock_select) begin
        clear_count = 1'b1;
    end
    if (service_write) begin
        clear_count = 1'b1;
    end
    if (first_write_first || first_write_second) begin
        clear_count = 1'b1;
    end
    if (!watchdog_enable || pulse_active) begin
        clear_count = 1'b1;
    end
    // A service write in the firing cycle still rescues the system.
    if (clear_count) begin
        next_watchdog_count = `WDT_CNT_ZERO;
    end else if (advance) begin
        if (count_plus == limit) begin
            fire = 1'b1;
            next_watchdog_count = `WDT_CNT_ZERO;
        end else begin
            next_watchdog_count = count_plus[`WDT_CNT_W-1:0];
        end
    end
end

always @(posedge clk_in or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
        watchdog_count <= `WDT_CNT_ZERO;
    end else begin
        watchdog_count <= next_watchdog_count;
    end
end

// ****************************************************************
// System reset pulse
// ****************************************************************
// The pulse lasts a fixed number of bus cycles so that the rest of the
// chip sees a clean reset even if it samples slowly.
always @(posedge clk_in or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
        system_reset_out <= 1'b0;
        pulse_count <= `WDT_PULSE_ZERO;
    end else if (fire) begin
        system_reset_out <= 1'b1;
        pulse_count <= RESET_PULSE_CYCLES[`WDT_PULSE_W-1:0] - `WDT_PULSE_ONE;
    end else if (pulse_active) begin
        if (pulse_count == `WDT_PULSE_ZERO) begin
            system_reset_out <= 1'b0;
        end else begin
            pulse_count <= pulse_count - `WDT_PULSE_ONE;
        end
    end
end

// ****************************************************************
// Reset cause
// ****************************************************************
// Bus writes to this address never change it; only resets do.
always @(posedge clk_in or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
        cause_power <= 1'b1;
        cause_watchdog <= 1'b0;
    end else if (fire) begin
        cause_power <= 1'b0;
        cause_watchdog <= 1'b1;
    end
end

endmodule // wdt_watchdog_timeout_reset

`default_nettype wire

// ==== wdt_defines.vh ====
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// ****************************************************************
// Register map (byte addresses on the APB bus)
// ****************************************************************
`define WDT_ADDR_W 8
`define WDT_OFS_RESET_CAUSE 8'h00
`define WDT_OFS_OPTIONS_FIRST 8'h04
`define WDT_OFS_OPTIONS_SECOND 8'h08
`define WDT_OFS_STATUS 8'h0c

// ****************************************************************
// Field positions
// ****************************************************************
`define WDT_BIT_ENABLE 7
`define WDT_BIT_TIMEOUT_SEL 6
`define WDT_BIT_CLOCK_SEL 7
`define WDT_BIT_CAUSE_POWER 7
`define WDT_BIT_CAUSE_WATCHDOG 5
`define WDT_BIT_LOCK_FIRST 24
`define WDT_BIT_LOCK_SECOND 25
`define WDT_BIT_RESET_ACTIVE 31

// ****************************************************************
// Reset values
// ****************************************************************
`define WDT_RST_ENABLE 1'b1
`define WDT_RST_TIMEOUT_SEL 1'b1
`define WDT_RST_CLOCK_SEL 1'b0
`define WDT_RST_WORD 32'h00000000

// ****************************************************************
// Counter and overflow counts (powers of two)
// ****************************************************************
`define WDT_CNT_W 18
`define WDT_LIMIT_ONE 19'h00001
`define WDT_CNT_ONE 18'h00001
`define WDT_CNT_ZERO 18'h00000
`define WDT_EXP_INT_SHORT 10
`define WDT_EXP_INT_LONG 13
`define WDT_EXP_BUS_SHORT 13
`define WDT_EXP_BUS_LONG 18

// ****************************************************************
// Timing
// ****************************************************************
`define WDT_CLK_PERIOD_NS 10
`define WDT_TICK_PERIOD_NS 1000000
`define WDT_RESET_PULSE_CYCLES 16
`define WDT_PULSE_W 8
`define WDT_PULSE_ONE 8'h01
`define WDT_PULSE_ZERO 8'h00

`endif

// ==== wdt_tick_sync.v ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Internal slow clock sampled into the bus clock domain
// ****************************************************************
module wdt_tick_sync (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Slow clock pin
    input wire slow_clk_in,
    // One-cycle pulse per slow clock rising edge
    output reg tick_out
);

reg sync_first;
reg sync_second;
reg sync_last;

// The first stage feeds only the second stage; the edge detector
// looks at the settled copy so metastability cannot fake a tick.
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        sync_first <= 1'b0;
        sync_second <= 1'b0;
        sync_last <= 1'b0;
        tick_out <= 1'b0;
    end else begin
        sync_first <= slow_clk_in;
        sync_second <= sync_first;
        sync_last <= sync_second;
        tick_out <= sync_second & ~sync_last;
    end
end

endmodule // wdt_tick_sync

`default_nettype wire

// ==== wdt_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"
// ******************************
// Port watcher for the watchdog
// ******************************
module wdt_monitor #(
    parameter RESET_PULSE_CYCLES = `WDT_RESET_PULSE_CYCLES
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [`WDT_ADDR_W-1:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire pready_out,
    input wire [31:0] prdata_out,
    input wire pslverr_out,
    // Slow clock and processor state
    input wire slow_clk_in,
    input wire stop_mode_in,
    input wire debug_mode_in,
    // Reset request
    input wire system_reset_out,
    input wire watchdog_enable_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire rd_setup = psel_in && !penable_in && !pwrite_in;
    wire svc_wr = psel_in && penable_in && pwrite_in && paddr_in == `WDT_OFS_RESET_CAUSE;
    logic [7:0] hi_cnt;
    // A fire is decided in the cycle before an edge and shows at the next sample, hence the ##1 below.
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) hi_cnt <= 8'h00;
        else if (system_reset_out) hi_cnt <= hi_cnt + 8'h01;
        else hi_cnt <= 8'h00;
    end
    property p_pulse_len; $fell(system_reset_out) |-> hi_cnt == RESET_PULSE_CYCLES; endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
    property p_enable_back; system_reset_out && $past(system_reset_out) |-> watchdog_enable_out; endproperty
    a_enable_back: assert property (p_enable_back) else $error("enable not restored");
    property p_disabled; !watchdog_enable_out |-> ##1 !$rose(system_reset_out); endproperty
    a_disabled: assert property (p_disabled) else $error("fired while disabled");
    property p_service; svc_wr && !system_reset_out |-> ##1 (!$rose(system_reset_out)) [*8]; endproperty
    a_service: assert property (p_service) else $error("fired after service");
    property p_hold; debug_mode_in || stop_mode_in |-> ##1 !$rose(system_reset_out); endproperty
    a_hold: assert property (p_hold) else $error("fired while held");
    property p_cause_bits; rd_setup && paddr_in == `WDT_OFS_RESET_CAUSE |=> (prdata_out & ~32'h000000a0) == 0;
    endproperty
    a_cause_bits: assert property (p_cause_bits) else $error("cause stray bits");
    property p_pulse_status; rd_setup && paddr_in == `WDT_OFS_STATUS && system_reset_out
        |=> prdata_out[17:0] == 18'h00000 && prdata_out[31]; endproperty
    a_pulse_status: assert property (p_pulse_status) else $error("counter not held in pulse");
    property p_stable; psel_in && penable_in |-> pready_out ##1 $stable(prdata_out); endproperty
    a_stable: assert property (p_stable) else $error("read data moved in access");
endmodule // wdt_monitor
bind wdt_watchdog_timeout_reset wdt_monitor #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) i_wdt_monitor (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
    .prdata_out(prdata_out), .pslverr_out(pslverr_out), .slow_clk_in(slow_clk_in),
    .stop_mode_in(stop_mode_in), .debug_mode_in(debug_mode_in), .system_reset_out(system_reset_out),
    .watchdog_enable_out(watchdog_enable_out));
`default_nettype wire

// ==== wdt_watchdog_timeout_reset_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"
module wdt_watchdog_timeout_reset_tb;
    localparam int PULSE = 4;
    localparam int SLOW_HALF = 37;
    localparam logic [7:0] CAUSE = `WDT_OFS_RESET_CAUSE;
    localparam logic [7:0] OPT1 = `WDT_OFS_OPTIONS_FIRST;
    localparam logic [7:0] OPT2 = `WDT_OFS_OPTIONS_SECOND;
    localparam logic [7:0] STAT = `WDT_OFS_STATUS;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h00000000;
    logic slow_clk_in = 1'b0;
    logic stop_mode_in = 1'b0;
    logic debug_mode_in = 1'b0;
    wire pready_out;
    wire pslverr_out;
    wire [31:0] prdata_out;
    wire system_reset_out;
    wire watchdog_enable_out;
    logic [31:0] rd;
    logic [31:0] held;
    logic [7:0] addr;
    logic err;
    int n_errors = 0;
    int n_checks = 0;
    int seed = 28;
    int waited;
    wdt_watchdog_timeout_reset #(.RESET_PULSE_CYCLES(PULSE)) i_wdt_watchdog_timeout_reset (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
        .prdata_out(prdata_out), .pslverr_out(pslverr_out), .slow_clk_in(slow_clk_in),
        .stop_mode_in(stop_mode_in), .debug_mode_in(debug_mode_in), .system_reset_out(system_reset_out),
        .watchdog_enable_out(watchdog_enable_out));
    // ******************************
    // Clocks and helpers
    // ******************************
    // The slow source is kept near 7.4 bus cycles so internal timeouts stay short.
    initial forever #5 clk_in = ~clk_in;
    initial forever #SLOW_HALF slow_clk_in = ~slow_clk_in;
    function automatic int limit_cycles(input logic clk_sel, input logic t_sel);
        if (clk_sel) return 1 << (t_sel ? `WDT_EXP_BUS_LONG : `WDT_EXP_BUS_SHORT);
        return (1 << (t_sel ? `WDT_EXP_INT_LONG : `WDT_EXP_INT_SHORT)) * 2 * SLOW_HALF / 10;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic near(input string what, input int got, input int exp);
        check(what, got * 50 > exp * 49 && got * 50 < exp * 51, 1'b1);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1) @(posedge clk_in);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic do_reset;
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic wait_fire(input int limit);
        waited = 0;
        while (system_reset_out !== 1'b1 && waited < limit) begin
            @(posedge clk_in);
            waited++;
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #1000000;
        n_errors++;
        final_report();
    end
    // ******************************
    // Scenarios
    // ******************************
    initial begin
        @(posedge clk_in);
        do_reset();
        apb(1'b0, OPT1, 32'h0);
        check("opt1_rst", rd, 32'h000000c0);
        apb(1'b0, OPT2, 32'h0);
        check("opt2_rst", rd, 32'h00000000);
        repeat (3) begin
            addr = $random(seed);
            apb(1'b1, addr | 8'h10, $random(seed));
            apb(1'b0, addr | 8'h10, 32'h0);
            check("unmapped_err", err, 1'b1);
            check("unmapped_data", rd, 32'h0);
        end
        apb(1'b1, OPT1, ($random(seed) & 32'hffffff3f) | 32'h00000080);
        apb(1'b1, OPT2, $random(seed) | 32'h00000080);
        apb(1'b1, OPT1, 32'h00000040);
        apb(1'b1, OPT2, 32'h00000000);
        apb(1'b0, OPT1, 32'h0);
        check("opt1_lock", rd, 32'h00000080);
        apb(1'b0, OPT2, 32'h0);
        check("opt2_lock", rd, 32'h00000080);
        apb(1'b0, STAT, 32'h0);
        check("locks", rd[25:24], 2'b11);
        repeat (500) @(posedge clk_in);
        apb(1'b1, CAUSE, $random(seed));
        apb(1'b0, STAT, 32'h0);
        check("svc_clear", rd[17:0] < 8, 1'b1);
        apb(1'b0, CAUSE, 32'h0);
        check("cause_ro", rd, 32'h00000080);
        for (int m = 0; m < 2; m++) begin
            {stop_mode_in, debug_mode_in} <= m ? 2'b10 : 2'b01;
            apb(1'b0, STAT, 32'h0);
            held = rd;
            repeat (9000) @(posedge clk_in);
            apb(1'b0, STAT, 32'h0);
            check("hold", rd[17:0], held[17:0]);
            {stop_mode_in, debug_mode_in} <= 2'b00;
            repeat (20) @(posedge clk_in);
            apb(1'b0, STAT, 32'h0);
            check("resume", rd[17:0] > held[17:0] && rd[17:0] - held[17:0] < 40, 1'b1);
        end
        apb(1'b1, CAUSE, 32'h0);
        wait_fire(9000);
        near("bus_fire", waited, limit_cycles(1'b1, 1'b0));
        apb(1'b0, STAT, 32'h0);
        check("pulse_stat", {rd[31], rd[17:0]}, {1'b1, 18'h00000});
        repeat (PULSE + 2) @(posedge clk_in);
        apb(1'b0, CAUSE, 32'h0);
        check("cause_wdt", rd, 32'h00000020);
        apb(1'b0, OPT1, 32'h0);
        check("opt1_back", rd, 32'h000000c0);
        repeat (300) @(posedge clk_in);
        apb(1'b1, OPT1, 32'h00000080);
        apb(1'b0, STAT, 32'h0);
        check("first_clear", rd[17:0] < 2, 1'b1);
        apb(1'b1, OPT2, 32'h0);
        stop_mode_in <= 1'b1;
        repeat (300) @(posedge clk_in);
        apb(1'b0, STAT, 32'h0);
        check("stop_zero", rd[17:0], 18'h00000);
        stop_mode_in <= 1'b0;
        wait_fire(9000);
        near("int_fire", waited, limit_cycles(1'b0, 1'b0));
        repeat (PULSE + 2) @(posedge clk_in);
        do_reset();
        apb(1'b0, CAUSE, 32'h0);
        check("cause_pin", rd, 32'h00000080);
        apb(1'b1, OPT1, 32'h0);
        apb(1'b1, OPT2, 32'h00000080);
        check("en_off", watchdog_enable_out, 1'b0);
        wait_fire(9000);
        check("no_fire", waited, 9000);
        final_report();
    end
endmodule // wdt_watchdog_timeout_reset_tb
`default_nettype wire
